/* hw/exec_mode_and_trace_control.sv */
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module exec_mode_and_trace_control
    import exec_trace_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // pipeline: system calls
    input  wire logic        call_valid,
    input  wire logic [7:0]  call_index,
    input  wire logic        call_trace_table,
    input  wire logic [31:0] call_ip,
    // pipeline: privileged instruction check
    input  wire logic        priv_valid,
    output logic             priv_fault,
    // pipeline: trace and fault events
    input  wire logic        trace_valid,
    input  wire logic [2:0]  trace_subtype,
    input  wire logic        fault_valid,
    input  wire logic        fault_return,
    // pipeline: results
    output logic             trace_fault,
    output logic             call_done,
    output logic [31:0]      target_ptr,
    output logic [31:0]      stack_ptr,
    output logic             supervisor_stack
);
    // =========================================================
    // state
    typedef enum {st_idle, st_fetch_entry, st_fetch_ssp} call_st_t;

    typedef struct packed {
        call_st_t    st;
        logic [31:0] ip;
        logic [31:0] ac;
        logic [31:0] pc;
        logic [31:0] tc;
        logic [31:0] ssp;
        logic [31:0] entry;
        logic        tbl_sel;
        logic [7:0]  idx;
        logic        sup_call;
        logic        trace_fault;
        logic        priv_fault;
        logic        call_done;
        logic [31:0] target;
        logic [31:0] stack;
        logic        sup_stack;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        tbl_we;
        logic [3:0]  tbl_idx;
        logic [31:0] tbl_data;
        logic        freq;
        logic [31:0] faddr;
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;

    table_fetch_if fetch ();

    // both tables share one layout; the trace table sits above the system one
    function automatic logic [31:0] table_addr(input logic sel, input logic [31:0] byte_off);
        table_addr = {26'h0, sel, 5'h0} + byte_off;
    endfunction : table_addr

    function automatic logic [31:0] entry_addr(input logic sel, input logic [7:0] idx);
        entry_addr = table_addr(sel, entry_byte_base + {24'h0, idx[5:0], 2'b00});
    endfunction : entry_addr

    table_memory #(.depth(16)) u_tables (
        .pclk      (pclk),
        .presetn   (presetn),
        .fetch     (fetch.table_port),
        .load_we   (state_reg.tbl_we),
        .load_idx  (state_reg.tbl_idx),
        .load_data (state_reg.tbl_data)
    );

    assign fetch.req  = state_reg.freq;
    assign fetch.addr = state_reg.faddr;

    logic apb_access;
    logic apb_wr;
    logic supervisor;
    logic trace_hit;

    assign apb_access = psel && penable && !state_reg.pready;
    assign apb_wr     = apb_access && pwrite;
    assign supervisor = state_reg.pc[pc_mode_bit];

    // =========================================================
    // next state
    always_comb begin
        state_next             = state_reg;
        state_next.trace_fault = 1'b0;
        state_next.priv_fault  = 1'b0;
        state_next.call_done   = 1'b0;
        state_next.tbl_we      = 1'b0;
        state_next.pready      = apb_access;
        state_next.pslverr     = 1'b0;
        trace_hit              = trace_valid && state_reg.pc[pc_trace_en_bit]
                                 && state_reg.tc[tc_mode_base + 32'(trace_subtype)];

        // apb writes; reserved bits are forced to zero, software should write zero anyway
        if (apb_wr) begin
            unique case (paddr)
                ip_offset:  state_next.ip = pwdata;
                ac_offset:  state_next.ac = pwdata;
                pc_offset:  state_next.pc = pwdata & pc_writable;
                tc_offset:  state_next.tc = pwdata & tc_writable;
                ctl_offset: state_next.pslverr = 1'b0;
                evt_offset: begin
                    state_next.tbl_we   = 1'b1;
                    state_next.tbl_idx  = pwdata[27:24];
                    state_next.tbl_data = {8'h0, pwdata[23:0]};
                end
                ssp_offset: state_next.ssp = pwdata;
                default:    state_next.pslverr = 1'b1;
            endcase
        end
        if (apb_access) begin
            unique case (paddr)
                ip_offset:   state_next.prdata = state_reg.ip;
                ac_offset:   state_next.prdata = state_reg.ac;
                pc_offset:   state_next.prdata = state_reg.pc;
                tc_offset:   state_next.prdata = state_reg.tc;
                ctl_offset:  state_next.prdata = 32'h0;
                evt_offset:  state_next.prdata = 32'h0;
                stat_offset: state_next.prdata = {31'h0, state_reg.st != st_idle};
                ssp_offset:  state_next.prdata = state_reg.ssp;
                default: begin
                    state_next.prdata  = 32'h0;
                    state_next.pslverr = 1'b1;
                end
            endcase
        end

        // privileged gate
        if (priv_valid) begin
            state_next.priv_fault = !supervisor;
        end

        // trace events: event flags set by hardware win over software clear
        // a code past the last subtype is dropped, else it would land on a reserved bit
        if (trace_valid && 32'(trace_subtype) < n_subtypes) begin
            state_next.tc[tc_event_base + 32'(trace_subtype)] = 1'b1;
        end
        if (trace_hit && fault_valid) begin
            state_next.pc[pc_pending_bit] = 1'b1;
        end else if (trace_hit) begin
            state_next.trace_fault = 1'b1;
        end
        if (fault_return && state_reg.pc[pc_pending_bit] && !(trace_hit && fault_valid)) begin
            state_next.trace_fault        = 1'b1;
            state_next.pc[pc_pending_bit] = 1'b0;
        end

        // system call sequence
        unique case (state_reg.st)
            st_idle: begin
                if (call_valid) begin
                    state_next.ip      = call_ip;
                    state_next.tbl_sel = call_trace_table;
                    state_next.idx     = call_index;
                    state_next.freq    = 1'b1;
                    state_next.faddr   = entry_addr(call_trace_table, call_index);
                    state_next.st      = st_fetch_entry;
                end
            end
            st_fetch_entry: begin
                if (fetch.ack) begin
                    state_next.entry    = fetch.data;
                    state_next.sup_call = fetch.data[1:0] == entry_type_supervisor[1:0];
                    state_next.faddr    = table_addr(state_reg.tbl_sel, ssp_byte_offset);
                    state_next.freq     = 1'b0;
                    state_next.st       = st_fetch_ssp;
                end
            end
            st_fetch_ssp: begin
                state_next.freq = !fetch.ack;
                if (fetch.ack) begin
                    state_next.target    = {state_reg.entry[31:2], 2'b00};
                    state_next.call_done = 1'b1;
                    state_next.st        = st_idle;
                    if (state_reg.sup_call && !supervisor) begin
                        state_next.pc[pc_mode_bit]     = 1'b1;
                        state_next.pc[pc_trace_en_bit] = fetch.data[0];
                        state_next.ssp                 = {fetch.data[31:2], 2'b00};
                        state_next.stack               = {fetch.data[31:2], 2'b00};
                        state_next.sup_stack           = 1'b1;
                    end else begin
                        state_next.stack     = supervisor ? state_reg.ssp : state_reg.stack;
                        state_next.sup_stack = supervisor;
                    end
                end
            end
            default: state_next.st = st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= '0;
            state_reg.st <= st_idle;
            state_reg.ip <= ip_reset;
            state_reg.ac <= ac_reset;
            state_reg.pc <= pc_reset;
            state_reg.tc <= tc_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata           = state_reg.prdata;
    assign pready           = state_reg.pready;
    assign pslverr          = state_reg.pslverr;
    assign priv_fault       = state_reg.priv_fault;
    assign trace_fault      = state_reg.trace_fault;
    assign call_done        = state_reg.call_done;
    assign target_ptr       = state_reg.target;
    assign stack_ptr        = state_reg.stack;
    assign supervisor_stack = state_reg.sup_stack;

    // =========================================================
    // checks
    property p_user_priv;
        @(posedge pclk) disable iff (!presetn)
        priv_valid && !supervisor |=> priv_fault;
    endproperty
    a_user_priv: assert property (p_user_priv) else $error("user privileged not refused");

    property p_sup_priv;
        @(posedge pclk) disable iff (!presetn)
        priv_valid && supervisor |=> !priv_fault;
    endproperty
    a_sup_priv: assert property (p_sup_priv) else $error("supervisor privileged refused");

    property p_trace_fault;
        @(posedge pclk) disable iff (!presetn)
        trace_hit && !fault_valid |=> trace_fault;
    endproperty
    a_trace_fault: assert property (p_trace_fault) else $error("trace event missed");

    property p_no_trace;
        @(posedge pclk) disable iff (!presetn)
        !state_reg.pc[pc_trace_en_bit] && !fault_return |=> !trace_fault;
    endproperty
    a_no_trace: assert property (p_no_trace) else $error("trace fault while disabled");

    property p_pending;
        @(posedge pclk) disable iff (!presetn)
        trace_hit && fault_valid |=> state_reg.pc[pc_pending_bit] && !trace_fault;
    endproperty
    a_pending: assert property (p_pending) else $error("pending not set");

    sequence s_return_pending;
        fault_return && state_reg.pc[pc_pending_bit] && !(trace_hit && fault_valid);
    endsequence
    property p_deferred;
        @(posedge pclk) disable iff (!presetn)
        s_return_pending |=> trace_fault && !state_reg.pc[pc_pending_bit];
    endproperty
    a_deferred: assert property (p_deferred) else $error("deferred trace fault lost");

    property p_event_flag;
        @(posedge pclk) disable iff (!presetn)
        trace_valid && 32'(trace_subtype) < n_subtypes |=> state_reg.tc[tc_event_base + 32'($past(trace_subtype))];
    endproperty
    a_event_flag: assert property (p_event_flag) else $error("event flag not set");

    sequence s_sup_call_end;
        state_reg.st == st_fetch_ssp && fetch.ack && state_reg.sup_call && !supervisor;
    endsequence
    property p_sup_switch;
        @(posedge pclk) disable iff (!presetn)
        s_sup_call_end |=> supervisor && supervisor_stack && call_done;
    endproperty
    a_sup_switch: assert property (p_sup_switch) else $error("no supervisor switch");

    property p_call_bound;
        @(posedge pclk) disable iff (!presetn)
        state_reg.st == st_idle && call_valid |-> ##[3:6] call_done;
    endproperty
    a_call_bound: assert property (p_call_bound) else $error("system call stalled");

    // one wait state: pready follows the access edge and stands a single cycle
    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        apb_access |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("bus answer timing wrong");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        apb_access && paddr > ssp_offset |=> pready && pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_tc_reserved;
        @(posedge pclk) disable iff (!presetn)
        (state_reg.tc & ~tc_writable) == 32'h0;
    endproperty
    a_tc_reserved: assert property (p_tc_reserved) else $error("reserved trace bit set");

    sequence s_other_call_end;
        state_reg.st == st_fetch_ssp && fetch.ack && !(state_reg.sup_call && !supervisor);
    endsequence
    property p_other_call;
        @(posedge pclk) disable iff (!presetn)
        s_other_call_end |=> call_done && supervisor_stack == $past(supervisor);
    endproperty
    a_other_call: assert property (p_other_call) else $error("stack choice wrong");

    property p_sup_load;
        @(posedge pclk) disable iff (!presetn)
        s_sup_call_end |=> stack_ptr == ($past(fetch.data) & 32'hffff_fffc)
                           && (state_reg.pc & 32'h1) == ($past(fetch.data) & 32'h1);
    endproperty
    a_sup_load: assert property (p_sup_load) else $error("table word not loaded");
endmodule : exec_mode_and_trace_control

/* hw/exec_trace_pkg.sv */
package exec_trace_pkg;

    // =========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [11:0] ip_offset   = 12'h000;
    localparam logic [11:0] ac_offset   = 12'h004;
    localparam logic [11:0] pc_offset   = 12'h008;
    localparam logic [11:0] tc_offset   = 12'h00c;
    localparam logic [11:0] ctl_offset  = 12'h010;
    localparam logic [11:0] evt_offset  = 12'h014;
    localparam logic [11:0] stat_offset = 12'h018;
    localparam logic [11:0] ssp_offset  = 12'h01c;

    // =========================================================
    // reset values
    localparam logic [31:0] ip_reset = 32'h0000_0000;
    localparam logic [31:0] ac_reset = 32'h0000_0000;
    localparam logic [31:0] pc_reset = 32'h0000_0000;
    localparam logic [31:0] tc_reset = 32'h0000_0000;

    // =========================================================
    // process control fields
    localparam int pc_trace_en_bit = 0;
    localparam int pc_mode_bit     = 1;
    localparam int pc_pending_bit  = 10;
    localparam logic [31:0] pc_writable = 32'h0000_0403;

    // =========================================================
    // trace control fields: mode bits 1..7, event bits 17..23
    localparam int n_subtypes    = 7;
    localparam int tc_mode_base  = 1;
    localparam int tc_event_base = 17;
    localparam logic [31:0] tc_writable = 32'h00fe_00fe;

    // =========================================================
    // system table layout
    localparam logic [7:0] entry_type_supervisor = 8'h02;
    localparam logic [31:0] ssp_byte_offset      = 32'h0000_000c;
    localparam logic [31:0] entry_byte_base      = 32'h0000_0030;
    localparam int ctl_tbl_busy_bit = 0;

    // =========================================================
    // event port encodings
    typedef enum logic [2:0] {
        sub_instruction,
        sub_branch,
        sub_call,
        sub_return,
        sub_prereturn,
        sub_supervisor,
        sub_breakpoint
    } trace_subtype_t;

endpackage : exec_trace_pkg

/* hw/table_fetch_if.sv */
`timescale 1ns/1ps
interface table_fetch_if;
    logic        req;
    logic [31:0] addr;
    logic        ack;
    logic [31:0] data;
    modport core  (output req, output addr, input ack, input data);
    modport table_port (input req, input addr, output ack, output data);
endinterface : table_fetch_if

/* hw/table_memory.sv */
`timescale 1ns/1ps
module table_memory
    import exec_trace_pkg::*;
#(
    parameter int depth = 16
) (
    // clock and reset
    input  wire logic    pclk,
    input  wire logic    presetn,
    // table fetch port
    table_fetch_if.table_port fetch,
    // software load port
    input  wire logic        load_we,
    input  wire logic [3:0]  load_idx,
    input  wire logic [31:0] load_data
);
    // =========================================================
    // state
    typedef struct packed {
        logic        ack;
        logic [31:0] data;
    } mem_state_t;

    logic [31:0] words [depth];
    mem_state_t  state_reg;
    mem_state_t  state_next;

    always_ff @(posedge pclk) begin
        if (load_we) begin
            words[load_idx] <= load_data;
        end
    end

    always_comb begin
        state_next      = state_reg;
        state_next.ack  = fetch.req && !state_reg.ack;
        state_next.data = words[fetch.addr[5:2]];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign fetch.ack  = state_reg.ack;
    assign fetch.data = state_reg.data;
endmodule : table_memory

/* test/pipe_model.sv */
`timescale 1ns/1ps
// ==========================================
// pipeline stand-in: one-cycle pulses launched just after a rising edge
module pipe_model (
    // clock
    input  wire logic        pclk,
    // requests toward the core
    output logic             call_valid,
    output logic [7:0]       call_index,
    output logic             call_trace_table,
    output logic [31:0]      call_ip,
    output logic             priv_valid,
    output logic             trace_valid,
    output logic [2:0]       trace_subtype,
    output logic             fault_valid,
    output logic             fault_return,
    // results from the core
    input  wire logic        priv_fault,
    input  wire logic        trace_fault
);
    initial begin
        {call_valid, call_trace_table, priv_valid, trace_valid, fault_valid, fault_return} = 6'h00;
        call_index    = 8'h00;
        call_ip       = 32'h0000_0000;
        trace_subtype = 3'h0;
    end

    // only indices 0..3 fit a table, larger ones wrap onto other words
    task automatic issue_call(input logic tt, input logic [7:0] idx, input logic [31:0] ip);
        @(posedge pclk);
        call_valid       <= 1'b1;
        call_index       <= idx;
        call_trace_table <= tt;
        call_ip          <= ip;
        @(posedge pclk);
        call_valid <= 1'b0;
    endtask : issue_call

    // results are registered, so they are read one edge after the pulse is launched
    task automatic issue_event(input logic pv, input logic tv, input logic fv, input logic fr,
                               input logic [2:0] sub, output logic pf, output logic tf);
        @(posedge pclk);
        priv_valid    <= pv;
        trace_valid   <= tv;
        trace_subtype <= sub;
        fault_valid   <= fv;
        fault_return  <= fr;
        @(posedge pclk);
        {priv_valid, trace_valid, fault_valid, fault_return} <= 4'h0;
        #1;
        pf = priv_fault;
        tf = trace_fault;
    endtask : issue_event
endmodule : pipe_model

/* test/test_exec_mode_and_trace_control.sv */
`timescale 1ns/1ps
module test_exec_mode_and_trace_control
    import exec_trace_pkg::*;
();
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        call_valid;
    logic [7:0]  call_index;
    logic        call_trace_table;
    logic [31:0] call_ip;
    logic        priv_valid;
    logic        priv_fault;
    logic        trace_valid;
    logic [2:0]  trace_subtype;
    logic        fault_valid;
    logic        fault_return;
    logic        trace_fault;
    logic        call_done;
    logic [31:0] target_ptr;
    logic [31:0] stack_ptr;
    logic        supervisor_stack;
    logic [31:0] rd;
    logic        err;
    logic        pf;
    logic        tf;
    int          n_fail;
    int          total_checks;

    exec_mode_and_trace_control dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .call_valid(call_valid), .call_index(call_index), .call_trace_table(call_trace_table),
        .call_ip(call_ip), .priv_valid(priv_valid), .priv_fault(priv_fault),
        .trace_valid(trace_valid), .trace_subtype(trace_subtype), .fault_valid(fault_valid),
        .fault_return(fault_return), .trace_fault(trace_fault), .call_done(call_done),
        .target_ptr(target_ptr), .stack_ptr(stack_ptr), .supervisor_stack(supervisor_stack)
    );

    pipe_model pipe (
        .pclk(pclk), .call_valid(call_valid), .call_index(call_index),
        .call_trace_table(call_trace_table), .call_ip(call_ip), .priv_valid(priv_valid),
        .trace_valid(trace_valid), .trace_subtype(trace_subtype), .fault_valid(fault_valid),
        .fault_return(fault_return), .priv_fault(priv_fault), .trace_fault(trace_fault)
    );

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run_call(input logic tt, input logic [7:0] idx, input logic [31:0] ip);
        int n;
        n = 0;
        pipe.issue_call(tt, idx, ip);
        while (call_done !== 1'b1 && n < 50) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check(32'(call_done), 32'h1);
    endtask : run_call

    task complete_run;
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // ==========================================
    // scenarios
    task automatic t_reset_regs;
        apb(1'b0, ip_offset, 32'h0);
        check(rd, ip_reset);
        apb(1'b0, ac_offset, 32'h0);
        check(rd, ac_reset);
        apb(1'b0, pc_offset, 32'h0);
        check(rd, pc_reset);
        apb(1'b0, tc_offset, 32'h0);
        check(rd, tc_reset);
        apb(1'b0, 12'h020, 32'h0);
        check({rd[30:0], err}, 32'h1);
        check(32'(supervisor_stack), 32'h0);
        pipe.issue_event(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, pf, tf);
        check(32'(pf), 32'h1);
    endtask : t_reset_regs

    task automatic t_tc_fields;
        apb(1'b1, tc_offset, 32'h00fe_00fe);
        apb(1'b0, tc_offset, 32'h0);
        check(rd, 32'h00fe_00fe);
        apb(1'b1, tc_offset, 32'h0000_0004);
    endtask : t_tc_fields

    // word 3 stack pointer with trace bit set, 11 trace-table stack pointer, 12/4 entries, 13 local entry
    task automatic t_calls;
        apb(1'b1, evt_offset, 32'h0300_1001);
        apb(1'b1, evt_offset, 32'h0b00_2000);
        apb(1'b1, evt_offset, 32'h0c00_0102);
        apb(1'b1, evt_offset, 32'h0400_0302);
        apb(1'b1, evt_offset, 32'h0d00_0201);
        run_call(1'b0, 8'h01, 32'h0000_4440);
        check(target_ptr, 32'h0000_0200);
        check({stack_ptr[30:0], supervisor_stack}, 32'h0);
        apb(1'b0, ip_offset, 32'h0);
        check(rd, 32'h0000_4440);
        run_call(1'b0, 8'h00, 32'h0000_5550);
        check(target_ptr, 32'h0000_0100);
        check({stack_ptr[31:1], supervisor_stack}, 32'h0000_1001);
        apb(1'b0, pc_offset, 32'h0);
        check(rd, 32'h0000_0003);
        pipe.issue_event(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, pf, tf);
        check(32'(pf), 32'h0);
    endtask : t_calls

    task automatic t_trace_subtypes;
        for (int s = 0; s <= n_subtypes; s++) begin
            pipe.issue_event(1'b0, 1'b1, 1'b0, 1'b0, 3'(s), pf, tf);
            check(32'(tf), 32'(s == 1));
        end
        apb(1'b0, tc_offset, 32'h0);
        check(rd, 32'h00fe_0004);
    endtask : t_trace_subtypes

    task automatic t_deferred;
        pipe.issue_event(1'b0, 1'b1, 1'b1, 1'b0, 3'h1, pf, tf);
        check(32'(tf), 32'h0);
        apb(1'b0, pc_offset, 32'h0);
        check(rd, 32'h0000_0403);
        pipe.issue_event(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, pf, tf);
        check(32'(tf), 32'h1);
        pipe.issue_event(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, pf, tf);
        check(32'(tf), 32'h0);
        apb(1'b0, pc_offset, 32'h0);
        check(rd, 32'h0000_0003);
    endtask : t_deferred

    task automatic t_trace_off_and_table;
        apb(1'b1, pc_offset, 32'h0000_0002);
        pipe.issue_event(1'b0, 1'b1, 1'b0, 1'b0, 3'h1, pf, tf);
        check(32'(tf), 32'h0);
        apb(1'b1, pc_offset, 32'h0000_0000);
        run_call(1'b1, 8'h00, 32'h0000_6660);
        check(target_ptr, 32'h0000_0300);
        check({stack_ptr[31:1], supervisor_stack}, 32'h0000_2001);
        apb(1'b0, pc_offset, 32'h0);
        check(rd, 32'h0000_0002);
    endtask : t_trace_off_and_table

    // ==========================================
    // clock, sequence and watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr        = 12'h000;
        pwdata       = 32'h0000_0000;
        n_fail       = 0;
        total_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_regs();
        t_tc_fields();
        t_calls();
        t_trace_subtypes();
        t_deferred();
        t_trace_off_and_table();
        complete_run();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        complete_run();
    end
endmodule : test_exec_mode_and_trace_control
